/* dual_slope_pkg.sv */
package dual_slope_pkg;
   // ------------------------------------------------------------
   // timebase and phase timing
   // ------------------------------------------------------------
   // oscillator rising edges per converter timebase tick
   localparam int unsigned DIV_RATIO = 4;
   // timebase ticks per unit of (256 - load value), as a shift
   localparam int unsigned PHASE_SHIFT = 8;
   // width of the span (256 - load value)
   localparam int unsigned SPAN_W = 9;
   // span base: 256
   localparam logic [8:0] SPAN_BASE = 9'h100;
   // integrator clear phase length in timebase ticks
   localparam int unsigned CLEAR_TICKS = 16;
   // width of the phase timer and of the result word
   localparam int unsigned COUNT_W = 18;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   // load value after reset: 0 gives the longest phases
   localparam logic [7:0] LOAD_RESET = 8'h00;
   // one-hot phase codes
   typedef enum logic [3:0] {
      ST_OFFSET = 4'b0001,
      ST_INTEG = 4'b0010,
      ST_DEINT = 4'b0100,
      ST_CLEAR = 4'b1000
   } phase_t;
endpackage : dual_slope_pkg

/* timebase_if.sv */
`timescale 1ns/1ps
// carries the divided timebase tick from divider to sequencer
interface timebase_if;
   logic tick; // one-cycle pulse per timebase period
   modport src (output tick);
   modport snk (input tick);
endinterface : timebase_if

/* timebase_divider.sv */
`timescale 1ns/1ps
module timebase_divider #(
   parameter int unsigned DIV = dual_slope_pkg::DIV_RATIO
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic timebase_clock_in,
   timebase_if.src tb
);
   // ------------------------------------------------------------
   // oscillator edge detect and divide
   // ------------------------------------------------------------
   logic osc_q; // previous oscillator level
   logic osc_d;
   logic [3:0] div_q; // rising edges seen in this period
   logic [3:0] div_d;
   logic tick_q; // registered tick pulse
   logic tick_d;
   logic rise; // oscillator rising edge

   // next values: every DIV rising edges give one tick
   always_comb begin
      rise = timebase_clock_in & ~osc_q;
      osc_d = timebase_clock_in;
      div_d = div_q;
      tick_d = 1'b0;
      if (rise) begin
         if (div_q == 4'(DIV - 1)) begin
            div_d = 4'h0;
            tick_d = 1'b1;
         end else begin
            div_d = div_q + 4'h1;
         end
      end
   end

   // register stage
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         osc_q <= 1'b0;
         div_q <= 4'h0;
         tick_q <= 1'b0;
      end else begin
         osc_q <= osc_d;
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   assign tb.tick = tick_q;
endmodule : timebase_divider

/* dual_slope_phase_sequencer.sv */
`timescale 1ns/1ps
// How it works
// - integrate fixed time, count deintegrate to zero
// - four phases in every measurement cycle
// - offset cancel length from loaded value
// - integrate length from loaded value
// - sample comparator at integrate end for sign
// - deintegrate counts until comparator reports crossing
// - count moves to output register at end
// - integrator clear runs right before offset cancel
// - timebase is oscillator divided by four
// - offset cancel and integrate equal length
// - deintegrate starts right after integrate, stops
// - done low during offset cancel only
// - reset high halts in offset cancel
module dual_slope_phase_sequencer #(
   parameter int unsigned CW = dual_slope_pkg::COUNT_W,
   parameter int unsigned CLEAR_LEN = dual_slope_pkg::CLEAR_TICKS
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic timebase_clock_in,
   input wire logic reset_in,
   input wire logic comparator_in,
   input wire logic [7:0] load_value_in,
   input wire logic load_strobe_in,
   output logic offset_cancel_phase_out,
   output logic integrate_phase_out,
   output logic reference_deintegrate_phase_out,
   output logic integrator_clear_phase_out,
   output logic conv_done_n_out,
   output logic conv_done_oe_out,
   output logic [CW-1:0] result_data_out,
   output logic polarity_bit_out,
   output logic overrange_out,
   output logic result_load_out
);
   // ------------------------------------------------------------
   // timebase
   // ------------------------------------------------------------
   timebase_if tb_link ();

   timebase_divider #(
      .DIV(dual_slope_pkg::DIV_RATIO)
   ) u_div (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .timebase_clock_in(timebase_clock_in),
      .tb(tb_link.src)
   );

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   dual_slope_pkg::phase_t state_q; // current phase, one-hot
   dual_slope_pkg::phase_t state_d;
   logic [CW-1:0] cnt_q; // ticks since phase entry
   logic [CW-1:0] cnt_d;
   logic [7:0] load_q; // loaded timing byte
   logic [7:0] load_d;
   logic sign_q; // polarity latched at integrate end
   logic sign_d;
   logic pol_q; // sign handed out together with the result word
   logic pol_d;
   logic [CW-1:0] result_q; // converted data word
   logic [CW-1:0] result_d;
   logic ovr_q; // deintegrate ran out without crossing
   logic ovr_d;
   logic done_q; // one-cycle transfer pulse
   logic done_d;
   logic eoc_n_q; // active-low done level
   logic eoc_n_d;
   logic [dual_slope_pkg::SPAN_W-1:0] span; // 256 - load value
   logic [CW-1:0] len; // offset cancel and integrate length
   logic [CW-1:0] deint_max; // deintegrate limit, twice len

   // ------------------------------------------------------------
   // phase length
   // ------------------------------------------------------------
   // phase length from the loaded byte; shared so both phases match
   // length follows load_q live, so a load mid-phase can cut or stretch it
   always_comb begin
      span = dual_slope_pkg::SPAN_BASE - {1'b0, load_q};
      len = CW'(CW'(span) << dual_slope_pkg::PHASE_SHIFT);
      deint_max = CW'(len << 1);
   end

   // ------------------------------------------------------------
   // phase sequencer
   // ------------------------------------------------------------
   // next-state logic, stepped once per timebase tick
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      load_d = load_q;
      sign_d = sign_q;
      pol_d = pol_q;
      result_d = result_q;
      ovr_d = ovr_q;
      done_d = 1'b0;
      // new byte takes effect from the next comparison on
      if (load_strobe_in) begin
         load_d = load_value_in;
      end
      if (tb_link.tick) begin
         unique case (state_q)
            dual_slope_pkg::ST_OFFSET: begin
               if (cnt_q == len - CW'(1)) begin
                  state_d = dual_slope_pkg::ST_INTEG;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + CW'(1);
               end
            end
            dual_slope_pkg::ST_INTEG: begin
               if (cnt_q == len - CW'(1)) begin
                  sign_d = comparator_in;
                  state_d = dual_slope_pkg::ST_DEINT;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + CW'(1);
               end
            end
            dual_slope_pkg::ST_DEINT: begin
               if (comparator_in != sign_q) begin
                  result_d = cnt_q;
                  // sign travels with the count so the word never mixes cycles
                  pol_d = sign_q;
                  ovr_d = 1'b0;
                  done_d = 1'b1;
                  state_d = dual_slope_pkg::ST_CLEAR;
                  cnt_d = '0;
               end else if (cnt_q == deint_max - CW'(1)) begin
                  // no crossing in time: report full count as overrange
                  result_d = cnt_q;
                  pol_d = sign_q;
                  ovr_d = 1'b1;
                  done_d = 1'b1;
                  state_d = dual_slope_pkg::ST_CLEAR;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + CW'(1);
               end
            end
            dual_slope_pkg::ST_CLEAR: begin
               if (cnt_q == CW'(CLEAR_LEN - 1)) begin
                  state_d = dual_slope_pkg::ST_OFFSET;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + CW'(1);
               end
            end
            default: begin
               // an illegal code falls back to offset cancel
               state_d = dual_slope_pkg::ST_OFFSET;
               cnt_d = '0;
            end
         endcase
      end
      if (reset_in) begin
         // held at offset cancel; a new cycle starts on release
         state_d = dual_slope_pkg::ST_OFFSET;
         cnt_d = '0;
      end
      eoc_n_d = (state_d != dual_slope_pkg::ST_OFFSET);
   end

   // register stage
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= dual_slope_pkg::ST_OFFSET;
         cnt_q <= '0;
         load_q <= dual_slope_pkg::LOAD_RESET;
         sign_q <= 1'b0;
         pol_q <= 1'b0;
         result_q <= '0;
         ovr_q <= 1'b0;
         done_q <= 1'b0;
         eoc_n_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         load_q <= load_d;
         sign_q <= sign_d;
         pol_q <= pol_d;
         result_q <= result_d;
         ovr_q <= ovr_d;
         done_q <= done_d;
         eoc_n_q <= eoc_n_d;
      end
   end

   // ------------------------------------------------------------
   // outputs straight from flip-flops, except conv_done_n_out tied low and conv_done_oe_out inverted from eoc_n_q
   // ------------------------------------------------------------
   assign offset_cancel_phase_out = state_q[0];
   assign integrate_phase_out = state_q[1];
   assign reference_deintegrate_phase_out = state_q[2];
   assign integrator_clear_phase_out = state_q[3];
   // open drain: value low, enable high only while pulling low
   assign conv_done_n_out = 1'b0;
   assign conv_done_oe_out = ~eoc_n_q;
   assign result_data_out = result_q;
   // the output sign moves only at capture, not at integrate end
   assign polarity_bit_out = pol_q;
   assign overrange_out = ovr_q;
   assign result_load_out = done_q;
endmodule : dual_slope_phase_sequencer

/* dual_slope_phase_sequencer_checker.sv */
`timescale 1ns/1ps
// phase order, done flag and result capture seen at the top ports
module dual_slope_phase_sequencer_checker #(
   parameter int unsigned CW = 18
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic reset_in,
   input wire logic offset_cancel_phase_out,
   input wire logic integrate_phase_out,
   input wire logic reference_deintegrate_phase_out,
   input wire logic integrator_clear_phase_out,
   input wire logic conv_done_oe_out,
   input wire logic [CW-1:0] result_data_out,
   input wire logic polarity_bit_out,
   input wire logic result_load_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   // one-cycle capture pulse
   sequence capture_s;
      result_load_out ##1 !result_load_out;
   endsequence
   // halt request held for two edges
   sequence halt_s;
      reset_in [*2];
   endsequence
   phase_onehot_a: assert property ($onehot({offset_cancel_phase_out, integrate_phase_out,
      reference_deintegrate_phase_out, integrator_clear_phase_out})) else $error("phase not one-hot");
   done_follows_a: assert property (conv_done_oe_out == offset_cancel_phase_out)
      else $error("done flag off its phase");
   deint_start_a: assert property ($rose(reference_deintegrate_phase_out)
      |-> $past(integrate_phase_out)) else $error("deintegrate not after integrate");
   clear_start_a: assert property ($rose(integrator_clear_phase_out)
      |-> $past(reference_deintegrate_phase_out)) else $error("clear not after deintegrate");
   offset_start_a: assert property ($rose(offset_cancel_phase_out) |->
      $past(integrator_clear_phase_out) || $past(reset_in)) else $error("offset not after clear");
   integ_start_a: assert property ($rose(integrate_phase_out)
      |-> $past(offset_cancel_phase_out)) else $error("integrate not after offset");
   capture_pulse_a: assert property ($rose(integrator_clear_phase_out) |-> capture_s)
      else $error("no capture pulse");
   result_held_a: assert property (!result_load_out |-> $stable(result_data_out)
      && $stable(polarity_bit_out)) else $error("result moved without capture");
   halt_offset_a: assert property (halt_s |=> offset_cancel_phase_out)
      else $error("halt left offset phase");
endmodule : dual_slope_phase_sequencer_checker
bind dual_slope_phase_sequencer dual_slope_phase_sequencer_checker #(.CW(CW)) i_checker (
   .sys_clk_in, .rstn_in, .reset_in, .offset_cancel_phase_out, .integrate_phase_out,
   .reference_deintegrate_phase_out, .integrator_clear_phase_out, .conv_done_oe_out,
   .result_data_out, .polarity_bit_out, .result_load_out);

/* integrator_model.sv */
`timescale 1ns/1ps
// integrator and comparator: output flips after a commanded tick count
module integrator_model (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic timebase_clock_in,
   input wire logic deint_in,
   input wire logic sign_in,
   input wire logic [31:0] cross_in,
   output logic comparator_out
);
   logic osc_q; // last oscillator level
   logic [1:0] rise_q; // rises modulo four, as the divider counts
   logic [31:0] ticks_q; // deintegrate ticks so far
   // follow the divided timebase so the ramp ends on a real tick
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         osc_q <= 1'b0;
         rise_q <= 2'h0;
         ticks_q <= 32'h0;
      end else begin
         osc_q <= timebase_clock_in;
         if (timebase_clock_in && !osc_q) rise_q <= rise_q + 2'h1;
         if (!deint_in) ticks_q <= 32'h0;
         else if (timebase_clock_in && !osc_q && rise_q == 2'h3) ticks_q <= ticks_q + 32'h1;
      end
   end
   // input polarity shows until the ramp crosses zero
   assign comparator_out = (deint_in && ticks_q >= cross_in) ? !sign_in : sign_in;
endmodule : integrator_model

/* dual_slope_phase_sequencer_tb.sv */
`timescale 1ns/1ps
module dual_slope_phase_sequencer_tb;
   logic sys_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic timebase_clock_in = 1'b0;
   logic reset_in = 1'b0;
   logic load_strobe_in = 1'b0;
   logic [7:0] load_value_in = 8'h00;
   logic comparator_in, offset_cancel_phase_out, integrate_phase_out, polarity_bit_out;
   logic reference_deintegrate_phase_out, integrator_clear_phase_out, overrange_out;
   logic conv_done_n_out, conv_done_oe_out, result_load_out;
   logic [17:0] result_data_out;
   logic sign_s = 1'b0; // commanded input polarity
   int cross_n = 0; // commanded ramp length in ticks
   int fail_count = 0;
   int cmp_count = 0;
   int seed = 83;
   int n;
   logic osc_run = 1'b0; // oscillator still until reset ends
   always #5 sys_clk_in = ~sys_clk_in;
   // oscillator at half the clock: one timebase tick every 8 cycles
   always @(negedge sys_clk_in) if (osc_run) timebase_clock_in <= ~timebase_clock_in;
   dual_slope_phase_sequencer i_dut (.sys_clk_in, .rstn_in, .timebase_clock_in, .reset_in,
      .comparator_in, .load_value_in, .load_strobe_in, .offset_cancel_phase_out,
      .integrate_phase_out, .reference_deintegrate_phase_out, .integrator_clear_phase_out,
      .conv_done_n_out, .conv_done_oe_out, .result_data_out, .polarity_bit_out,
      .overrange_out, .result_load_out);
   integrator_model i_model (.sys_clk_in, .rstn_in, .timebase_clock_in,
      .deint_in(reference_deintegrate_phase_out), .sign_in(sign_s), .cross_in(cross_n),
      .comparator_out(comparator_in));
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   function automatic logic sig(input int s);
      case (s)
         0: return offset_cancel_phase_out;
         1: return integrate_phase_out;
         default: return result_load_out;
      endcase
   endfunction : sig
   // expected count: ticks to the crossing, or the full limit when none comes
   function automatic int exp_count(input int cn, input int ln);
      if (cn > 2 * ln) return 2 * ln - 1;
      return (cn == 0) ? 0 : cn - 1;
   endfunction : exp_count
   // bounded wait for a phase or the capture pulse
   task wait_hi(input int s);
      int k;
      for (k = 0; k < 20000 && sig(s) !== 1'b1; k++) @(negedge sys_clk_in);
      if (k == 20000) begin
         fail_count++;
         finish_test();
      end
   endtask : wait_hi
   task len_of(input int s, output int c);
      wait_hi(s);
      c = 0;
      while (sig(s) === 1'b1) begin
         c++;
         @(negedge sys_clk_in);
      end
   endtask : len_of
   // one conversion with polarity s and ramp length cn, phase length ln
   task convert(input logic s, input int cn, input int ln);
      logic ov;
      wait_hi(0);
      sign_s = s;
      cross_n = cn;
      wait_hi(2);
      ov = cn > 2 * ln;
      chk("result", exp_count(cn, ln), result_data_out);
      chk("sign", s, polarity_bit_out);
      chk("overrange", ov, overrange_out);
      chk("clear phase", 1, integrator_clear_phase_out);
   endtask : convert
   initial begin
      repeat (8) @(negedge sys_clk_in);
      rstn_in = 1'b1;
      osc_run = 1'b1;
      load_value_in = 8'hff;
      load_strobe_in = 1'b1;
      @(negedge sys_clk_in);
      load_strobe_in = 1'b0;
      len_of(1, n);
      chk("integrate len", 256 * 8, n);
      len_of(0, n);
      chk("offset len", 256 * 8, n);
      convert(1'b1, 0, 256);
      convert(1'b0, 1, 256);
      convert(1'b1, 512, 256);
      convert(1'b0, 513, 256);
      repeat (3) convert($random(seed) & 1, $random(seed) & 32'h1ff, 256);
      wait_hi(0);
      // halt raised only while done is low
      reset_in = 1'b1;
      repeat (300) @(negedge sys_clk_in);
      chk("halted", 1, offset_cancel_phase_out);
      chk("done oe", 1, conv_done_oe_out);
      chk("done value", 0, conv_done_n_out);
      reset_in = 1'b0;
      len_of(0, n);
      chk("resume len", 1, n >= 2040 && n <= 2056);
      wait_hi(0);
      load_value_in = 8'hfe;
      load_strobe_in = 1'b1;
      @(negedge sys_clk_in);
      load_strobe_in = 1'b0;
      len_of(1, n);
      chk("integrate len 2", 512 * 8, n);
      finish_test();
   end
   initial begin
      #1000000;
      fail_count++;
      finish_test();
   end
endmodule : dual_slope_phase_sequencer_tb
